// *** hdl/sadc_pkg.sv ***
package sadc_pkg;
   // register addresses on the peripheral bus
   localparam logic [15:0] ADDR_RESULT_WIDE = 16'hff18;
   localparam logic [15:0] ADDR_MODE = 16'hff80;
   localparam logic [15:0] ADDR_CHANNEL = 16'hff81;
   // high-byte result has no printed address
   localparam logic [15:0] ADDR_RESULT_HIGH = 16'hff1a;
   localparam logic [7:0] MODE_RESET = 8'h00;
   localparam logic [7:0] CHANNEL_RESET = 8'h00;
   // writable bits: run 7, timing 5..3, refgen 0
   localparam logic [7:0] MODE_WMASK = 8'hb9;
   localparam logic [7:0] CHANNEL_WMASK = 8'h03;
   localparam int RUN_BIT = 7;
   localparam int TSEL_LSB = 3;
   localparam int REFGEN_BIT = 0;
   localparam int RESULT_BITS = 10;
   localparam logic [7:0] SAMPLE_CYC [8] = '{8'h0c, 8'h18, 8'h30, 8'h58,
      8'h18, 8'h30, 8'h60, 8'hb0};
   localparam logic [7:0] TOTAL_CYC [8] = '{8'h24, 8'h30, 8'h48, 8'h70,
      8'h48, 8'h60, 8'h90, 8'he0};

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_SAMPLE = 4'b0010,
      ST_CONVERT = 4'b0100,
      ST_LOAD = 4'b1000
   } sadc_state_type;

   typedef enum logic [1:0] {
      OP_STOP = 2'b00,
      OP_WAIT = 2'b01,
      OP_CONVERT = 2'b10
   } sadc_opmode_type;
endpackage

// *** hdl/sadc_seq_if.sv ***
`timescale 1ns/100ps
interface sadc_seq_if;
   logic run;
   logic restart;
   logic [2:0] tsel;
   logic [9:0] result;
   logic done;
   modport ctl (output run, output restart, output tsel,
      input result, input done);
   modport seq (input run, input restart, input tsel,
      output result, output done);
endinterface // sadc_seq_if

// *** hdl/sadc_sequencer.sv ***
`timescale 1ns/100ps
module sadc_sequencer (
   input wire logic clk,
   input wire logic reset,
   sadc_seq_if.seq sq,
   input wire logic comp_high,
   output logic sample_hold,
   output logic [9:0] tap_select
);
   typedef struct packed {
      sadc_pkg::sadc_state_type st;
      logic [7:0] cnt;
      logic [3:0] bit_idx;
      logic [9:0] approx;
      logic done;
   } sadc_seq_type;

   sadc_seq_type q, d;

   function automatic logic [7:0] bit_span(input logic [2:0] t);
      // cycles per bit decision spread over conversion period
      bit_span = (sadc_pkg::TOTAL_CYC[t] - sadc_pkg::SAMPLE_CYC[t])
         / 8'(sadc_pkg::RESULT_BITS);
   endfunction

   always_comb begin
      d = q;
      d.done = 1'b0;
      case (q.st)
         sadc_pkg::ST_IDLE: begin
            if (sq.run) begin
               d.st = sadc_pkg::ST_SAMPLE;
               d.cnt = sadc_pkg::SAMPLE_CYC[sq.tsel] - 8'h01;
            end
         end
         sadc_pkg::ST_SAMPLE: begin
            if (q.cnt == 8'h00) begin
               d.st = sadc_pkg::ST_CONVERT;
               d.bit_idx = 4'(sadc_pkg::RESULT_BITS - 1);
               d.approx = 10'h200;
               d.cnt = bit_span(sq.tsel) - 8'h01;
            end else begin
               d.cnt = q.cnt - 8'h01;
            end
         end
         sadc_pkg::ST_CONVERT: begin
            if (q.cnt != 8'h00) begin
               d.cnt = q.cnt - 8'h01;
            end else begin
               // msb first, one comparator decision per bit
               d.approx[q.bit_idx] = comp_high;
               if (q.bit_idx == 4'h0) begin
                  d.st = sadc_pkg::ST_LOAD;
               end else begin
                  d.bit_idx = q.bit_idx - 4'h1;
                  d.approx[q.bit_idx - 4'h1] = 1'b1;
                  d.cnt = bit_span(sq.tsel) - 8'h01;
               end
            end
         end
         sadc_pkg::ST_LOAD: begin
            d.done = 1'b1;
            d.st = sadc_pkg::ST_SAMPLE;
            d.cnt = sadc_pkg::SAMPLE_CYC[sq.tsel] - 8'h01;
         end
         default: d.st = sadc_pkg::ST_IDLE;
      endcase
      if (!sq.run) begin
         d.st = sadc_pkg::ST_IDLE;
         d.done = 1'b0;
      end else if (sq.restart) begin
         d.st = sadc_pkg::ST_SAMPLE;
         d.cnt = sadc_pkg::SAMPLE_CYC[sq.tsel] - 8'h01;
         d.done = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         q <= '{st: sadc_pkg::ST_IDLE, cnt: 8'h00, bit_idx: 4'h0,
            approx: 10'h000, done: 1'b0};
      end else begin
         q <= d;
      end
   end

   assign sample_hold = (q.st == sadc_pkg::ST_SAMPLE);
   assign tap_select = q.approx;
   assign sq.result = q.approx;
   assign sq.done = q.done;
endmodule // sadc_sequencer

// *** hdl/sadc_control_regs.sv ***
`timescale 1ns/100ps
// Overview of operation
// - mode register: run, timing, refgen; reset zero
// - run bit zero holds converter stopped
// - timing select picks sample and total cycles
// - refgen bit drives reference generator enable
// - enable bits select stop, wait, convert
// - channel register bits 1:0 pick input
// - wide result loaded each conversion, upper zero
// - wide result read as one 16-bit access
// - byte result holds eight most significant bits
// - byte result read with 8-bit access
// - mode or channel write may spoil result
// - control registers accept bit and byte writes
// - done interrupt request each finished conversion
// - run held high repeats conversions back-to-back
// - control write aborts and restarts conversion
// - clearing run stops conversion immediately
module sadc_control_regs (
   input wire logic clk,
   input wire logic reset,
   input wire logic [15:0] bus_addr,
   input wire logic bus_wr,
   input wire logic bus_rd,
   input wire logic bus_wide,
   input wire logic [7:0] bus_bit_mask,
   input wire logic [15:0] bus_wdata,
   output logic [15:0] bus_rdata,
   input wire logic comparator_in,
   output logic [3:0] analog_input_sel,
   output logic sample_hold,
   output logic [9:0] tap_select,
   output logic refgen_enable,
   output logic converter_power,
   output logic [1:0] op_mode,
   output logic conversion_done_irq
);
   typedef struct packed {
      logic [7:0] mode;
      logic [7:0] chan;
      logic [9:0] result;
      logic [15:0] rdata;
      logic irq;
      logic restart;
      logic cmp_sync;
   } sadc_regs_type;

   sadc_regs_type q, d;
   sadc_seq_if sq ();

   // bit-set/clear writes touch only masked bits; full byte uses 8'hff
   function automatic logic [7:0] merge(input logic [7:0] old,
      input logic [7:0] wd, input logic [7:0] bm, input logic [7:0] wm);
      merge = ((old & ~bm) | (wd & bm)) & wm;
   endfunction

   logic wr_mode, wr_chan;
   assign wr_mode = bus_wr && !bus_wide && bus_addr == sadc_pkg::ADDR_MODE;
   assign wr_chan = bus_wr && !bus_wide &&
      bus_addr == sadc_pkg::ADDR_CHANNEL;

   always_comb begin
      d = q;
      // comparator follows our own tap register, so same clock domain;
      // a second stage would make a decision see the previous tap
      d.cmp_sync = comparator_in;
      // registered so the sequencer sees the new run bit with the restart:
      // a write that clears run must not start one more sample
      d.restart = wr_mode || wr_chan;
      d.irq = sq.done;
      if (wr_mode) begin
         d.mode = merge(q.mode, bus_wdata[7:0], bus_bit_mask,
            sadc_pkg::MODE_WMASK);
      end
      if (wr_chan) begin
         // upper bits kept zero regardless of what software writes
         d.chan = merge(q.chan, bus_wdata[7:0], bus_bit_mask,
            sadc_pkg::CHANNEL_WMASK);
      end
      if (sq.done) begin
         d.result = sq.result;
      end
      d.rdata = 16'h0000;
      if (bus_rd) begin
         case (bus_addr)
            sadc_pkg::ADDR_MODE: d.rdata = {8'h00, q.mode};
            sadc_pkg::ADDR_CHANNEL: d.rdata = {8'h00, q.chan};
            sadc_pkg::ADDR_RESULT_WIDE: begin
               // only a word access returns it
               if (bus_wide) begin
                  d.rdata = {6'h00, q.result};
               end
            end
            sadc_pkg::ADDR_RESULT_HIGH: begin
               if (!bus_wide) begin
                  d.rdata = {8'h00, q.result[9:2]};
               end
            end
            default: d.rdata = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         // result left as-is under reset is allowed; cleared for lint
         q <= '{mode: sadc_pkg::MODE_RESET, chan: sadc_pkg::CHANNEL_RESET,
            result: 10'h000, rdata: 16'h0000, irq: 1'b0,
            restart: 1'b0, cmp_sync: 1'b0};
      end else begin
         q <= d;
      end
   end

   assign sq.run = q.mode[sadc_pkg::RUN_BIT];
   // any control write that leaves run set restarts a running conversion; one that clears run stops it
   assign sq.restart = q.restart;
   assign sq.tsel = q.mode[sadc_pkg::TSEL_LSB +: 3];

   sadc_sequencer u_seq (
      .clk(clk),
      .reset(reset),
      .sq(sq),
      .comp_high(q.cmp_sync),
      .sample_hold(sample_hold),
      .tap_select(tap_select)
   );

   always_comb begin
      analog_input_sel = 4'h0;
      analog_input_sel[q.chan[1:0]] = 1'b1;
      op_mode = sadc_pkg::OP_STOP;
      if (q.mode[sadc_pkg::RUN_BIT]) begin
         op_mode = sadc_pkg::OP_CONVERT;
      end else if (q.mode[sadc_pkg::REFGEN_BIT]) begin
         op_mode = sadc_pkg::OP_WAIT;
      end
   end

   assign refgen_enable = q.mode[sadc_pkg::REFGEN_BIT];
   assign converter_power = q.mode[sadc_pkg::RUN_BIT];
   assign bus_rdata = q.rdata;
   assign conversion_done_irq = q.irq;
endmodule // sadc_control_regs

// *** tb/sadc_analog_model.sv ***
`timescale 1ns/100ps
module sadc_analog_model (
   input wire logic [9:0] tap_select,
   input wire logic [9:0] analog_level,
   output logic comparator_in
);
   // ideal comparator, no offset or noise
   assign comparator_in = analog_level >= tap_select;
endmodule // sadc_analog_model

// *** tb/sadc_control_regs_checker.sv ***
`timescale 1ns/100ps
module sadc_regs_checker (
   input wire logic clk,
   input wire logic reset,
   input wire logic [15:0] bus_addr,
   input wire logic bus_wr,
   input wire logic bus_rd,
   input wire logic bus_wide,
   input wire logic [7:0] bus_bit_mask,
   input wire logic [15:0] bus_wdata,
   input wire logic [15:0] bus_rdata,
   input wire logic [3:0] analog_input_sel,
   input wire logic sample_hold,
   input wire logic [9:0] tap_select,
   input wire logic refgen_enable,
   input wire logic converter_power,
   input wire logic [1:0] op_mode,
   input wire logic conversion_done_irq
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);
   a_stop_idle: assert property (
      !converter_power && !$past(converter_power) |-> !sample_hold)
      else $error("sampling while stopped");
   a_mode_conv: assert property (
      converter_power |-> op_mode == 2'b10) else $error("bad convert mode");
   a_mode_wait: assert property (
      !converter_power |-> op_mode == {1'b0, refgen_enable})
      else $error("bad stop or wait mode");
   a_irq_pulse: assert property (
      conversion_done_irq |=> !conversion_done_irq) else $error("long irq");
   a_sel_onehot: assert property (
      $onehot(analog_input_sel)) else $error("input select not one-hot");
   a_rdata_quiet: assert property (
      !$past(bus_rd) |-> bus_rdata == 16'h0000) else $error("stray rdata");
   a_tap_hold: assert property (
      sample_hold && $past(sample_hold) |-> $stable(tap_select))
      else $error("tap moved while sampling");
   a_msb_first: assert property (
      $fell(sample_hold) && converter_power |-> tap_select == 10'h200)
      else $error("conversion did not start at msb");
   a_mode_byte: assert property (
      bus_wr && !bus_wide && bus_addr == 16'hff80 && bus_bit_mask == 8'hff
      |=> ($past(bus_wdata) & 16'h0081) ==
      {8'h00, converter_power, 6'h00, refgen_enable})
      else $error("mode write lost");
   a_write_restart: assert property (
      converter_power && bus_wr && !bus_wide && bus_addr == 16'hff81
      |-> ##[1:2] sample_hold) else $error("no restart");
endmodule // sadc_regs_checker
bind sadc_control_regs sadc_regs_checker i_sadc_regs_checker (.*);

// *** tb/sadc_control_regs_tb.sv ***
`timescale 1ns/100ps
module sadc_control_regs_tb;
   logic clk, reset, bus_wr, bus_rd, bus_wide, rd_q;
   logic comparator_in, sample_hold, refgen_enable, converter_power;
   logic conversion_done_irq;
   logic [15:0] bus_addr, bus_wdata, bus_rdata;
   logic [7:0] bus_bit_mask;
   logic [9:0] tap_select, analog_level;
   logic [3:0] analog_input_sel;
   logic [1:0] op_mode;
   logic [15:0] exp_q [$];
   int error_cnt, n_checks, seed, n;
   sadc_control_regs i_sadc_control_regs (.*);
   sadc_analog_model i_sadc_analog_model (.*);
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic chk(string nm, logic [15:0] s, logic [15:0] e);
      n_checks++;
      if (s !== e) begin
         error_cnt++;
         $display("BAD %s exp %h seen %h", nm, e, s);
      end
   endtask
   task tally_and_finish;
      $display("errors %0d checks %0d", error_cnt, n_checks);
      if (error_cnt == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // trailing edge lets the register land before the caller looks
   task wr(logic [15:0] a, logic [7:0] d, logic [7:0] m);
      @(posedge clk);
      bus_addr <= a;
      bus_wdata <= {8'h00, d};
      bus_bit_mask <= m;
      bus_wr <= 1'b1;
      @(posedge clk);
      bus_wr <= 1'b0;
      @(posedge clk);
   endtask
   task rd(logic [15:0] a, logic w, logic [15:0] e);
      @(posedge clk);
      bus_addr <= a;
      bus_wide <= w;
      bus_rd <= 1'b1;
      exp_q.push_back(e);
      @(posedge clk);
      bus_rd <= 1'b0;
      bus_wide <= 1'b0;
   endtask
   task wait_for(logic v);
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (conversion_done_irq !== v && n < 300);
      chk("irq", 16'(conversion_done_irq), 16'(v));
   endtask
   always @(posedge clk) begin
      rd_q <= bus_rd;
      if (rd_q) chk("rdata", bus_rdata, exp_q.pop_front());
   end
   initial begin
      #100000;
      error_cnt++;
      tally_and_finish;
   end
   initial begin
      seed = 58;
      {reset, bus_wr, bus_rd, bus_wide} = 4'h8;
      bus_addr = 16'h0000;
      bus_wdata = 16'h0000;
      bus_bit_mask = 8'h00;
      analog_level = 10'h000;
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      rd(16'hff80, 1'b0, 16'h0000);
      rd(16'hff81, 1'b0, 16'h0000);
      rd(16'hff00, 1'b0, 16'h0000);
      rd(16'hff18, 1'b0, 16'h0000);
      // all bits but run: run never rises before the reference settles
      wr(16'hff80, 8'hff, 8'h7f);
      rd(16'hff80, 1'b0, 16'h0039);
      wr(16'hff80, 8'h00, 8'hff);
      for (int c = 0; c < 4; c++) begin
         wr(16'hff81, 8'(c), 8'hff);
         chk("sel", 16'(analog_input_sel), 16'(16'h0001 << c));
      end
      wr(16'hff80, 8'h01, 8'h01);
      chk("wait", 16'(op_mode), 16'h0001);
      repeat (200) @(posedge clk);
      for (int t = 0; t < 8; t++) begin
         analog_level <= 10'($random(seed));
         wr(16'hff80, {2'b10, 3'(t), 3'b001}, 8'hff);
         wait (sample_hold === 1'b1);
         // count settled values, one per cycle of sampling
         @(negedge clk);
         for (n = 0; sample_hold === 1'b1 && n < 300; n++) @(negedge clk);
         chk("sample", 16'(n), 16'(sadc_pkg::SAMPLE_CYC[t]));
         wait_for(1'b1);
         rd(16'hff18, 1'b1, {6'h00, analog_level});
         rd(sadc_pkg::ADDR_RESULT_HIGH, 1'b0,
            {8'h00, analog_level[9:2]});
         wait_for(1'b0);
         wait_for(1'b1);
         chk("again", 16'(conversion_done_irq), 16'h0001);
         wait (sample_hold === 1'b0);
         wr(16'hff81, 8'h02, 8'hff);
         @(posedge clk);
         chk("restart", 16'(sample_hold), 16'h0001);
         wr(16'hff80, 8'h00, 8'h80);
         @(posedge clk);
         chk("halt", 16'({sample_hold, op_mode}), 16'h0001);
         rd(16'hff80, 1'b0, {10'h000, 3'(t), 3'b001});
      end
      repeat (4) @(posedge clk);
      tally_and_finish;
   end
endmodule // sadc_control_regs_tb
